/* File: design/system_clock_prescaler_control.sv */
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "clk_presc_defs.svh"
// Notes on behaviour
// - Fuse code 0000 selects the external clock pin as system clock.
// - External clock start delay: 6 or 14 clocks, plus 4.1ms/65ms; code 11 reserved.
// - Clock output fuse enables the clock pin driver, also in reset, where the pin is held low.
// - Clock output pin carries the divided clock at codes 2 to 8; low at code 1, toggling each cycle at code 0.
// - Timer oscillator allowed only while an internal RC clock is used.
// - Timer input takes external clock only when its select bit is one.
// - All synchronous peripheral clocks are divided by the same factor.
// - Division changes produce no period shorter than old or new.
// - New rate active within T1+T2 to T1+2*T2, two edges between; here the new rate starts at the next divided edge, at most T1 after the write.
// - Change enable updates only when other bits are written zero.
// - Enable clears four cycles after set or on select write; no extension.
// - Reset loads select 0000, or 0011 when divide-by-eight fuse set.
// - Any code 0 to 8 is accepted via the unlock sequence regardless of fuse.
// - Codes 0 to 8 divide by two to the power code; others reserved.
// - Divider counter runs on the undivided clock; its state is hidden.
module system_clock_prescaler_control #(
  parameter int unsigned START_FAST_CYCLES = `START_FAST_CYCLES,
  parameter int unsigned START_SLOW_CYCLES = `START_SLOW_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fuses, static pins
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic initial_divide_by_eight_fuse,
  input wire logic clock_output_fuse,
  input wire logic wake_from_sleep,
  // Divided clock enables and pins
  output logic sys_clk_en,
  output logic system_clock_output_pin,
  output logic system_clock_output_oe_n,
  output logic ext_clock_select,
  output logic timer_osc_enable,
  output logic timer_ext_clock_accept,
  output logic startup_done
);
  // ----------------------------------------
  // Synchronisers for fuse and pin inputs
  // ----------------------------------------
  logic [7:0] fuse_meta_r, fuse_sync_r;
  logic [1:0] wake_meta_r;
  logic [1:0] sync_ok_r;
  // No reset: the clock output enable must follow its fuse during reset too
  always_ff @(posedge core_clk) begin
    fuse_meta_r <= {clock_output_fuse, initial_divide_by_eight_fuse,
                    startup_time_fuses, clock_source_select_fuses};
    fuse_sync_r <= fuse_meta_r;
  end
  // Marks the fuse pipeline as filled after release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_meta_r <= 2'h0;
      sync_ok_r <= 2'h0;
    end else begin
      wake_meta_r <= {wake_meta_r[0], wake_from_sleep};
      sync_ok_r <= {sync_ok_r[0], 1'b1};
    end
  end
  wire logic [3:0] src_sel = fuse_sync_r[3:0];
  wire logic [1:0] start_sel = fuse_sync_r[5:4];
  wire logic div8_fuse = fuse_sync_r[6];
  wire logic clk_out_fuse = fuse_sync_r[7];
  wire logic wake_s = wake_meta_r[1];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic acc = psel && penable;
  wire logic wr_ctrl = acc && pwrite && (paddr == `PRESC_CTRL_OFFSET);
  wire logic wr_cfg = acc && pwrite && (paddr == `CFG_OFFSET);
  wire logic known = (paddr == `PRESC_CTRL_OFFSET) || (paddr == `CFG_OFFSET) ||
                     (paddr == `STATUS_OFFSET);

  // ----------------------------------------
  // Change enable and select
  // ----------------------------------------
  logic pce_r;
  logic [2:0] pce_cnt_r;
  logic [3:0] ps_r;
  logic ps_loaded_r;
  logic tmr_ext_r;
  wire logic pce_write = wr_ctrl && pwdata[`PCE_BIT] && (pwdata[6:0] == 7'h00);
  wire logic ps_write = wr_ctrl && !pwdata[`PCE_BIT] && pce_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pce_r <= 1'b0;
      pce_cnt_r <= 3'h0;
    end else if (ps_write) begin
      pce_r <= 1'b0;
      pce_cnt_r <= 3'h0;
    end else if (pce_write && !pce_r) begin
      pce_r <= 1'b1;
      pce_cnt_r <= `PCE_TIMEOUT_CYCLES;
    end else if (pce_r) begin
      // Rewrites while armed leave the countdown untouched
      pce_cnt_r <= pce_cnt_r - 3'h1;
      if (pce_cnt_r == 3'h1) begin
        pce_r <= 1'b0;
      end
    end
  end

  // Reset value of select taken after release, once fuses are synchronised
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ps_r <= `PS_RESET_DIV1;
      ps_loaded_r <= 1'b0;
    end else if (!ps_loaded_r && sync_ok_r[1]) begin
      ps_loaded_r <= 1'b1;
      ps_r <= div8_fuse ? `PS_RESET_DIV8 : `PS_RESET_DIV1;
    end else if (ps_write && pwdata[`PS_MSB:0] <= `PS_MAX_CODE) begin
      ps_r <= pwdata[`PS_MSB:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_ext_r <= 1'b0;
    end else if (wr_cfg) begin
      tmr_ext_r <= pwdata[0];
    end
  end

  // ----------------------------------------
  // Glitch-free divider
  // ----------------------------------------
  // The active code only changes at a divided edge, so the period in flight
  // finishes at the old rate and the next one runs fully at the new rate.
  logic [3:0] act_ps_r;
  logic [7:0] div_cnt_r;
  logic en_r;
  logic clk_out_r;

  function automatic logic [7:0] div_limit(input logic [3:0] code);
    div_limit = 8'((9'h001 << code) - 9'h001);
  endfunction : div_limit

  wire logic div_wrap = (div_cnt_r >= div_limit(act_ps_r));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_r <= 8'h00;
      act_ps_r <= `PS_RESET_DIV1;
      en_r <= 1'b0;
    end else if (div_wrap) begin
      div_cnt_r <= 8'h00;
      act_ps_r <= ps_r;
      en_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
      en_r <= 1'b0;
    end
  end

  // Divided clock for the output pin, high one cycle less than half the period, so low at code 1; undivided code toggles raw
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_out_r <= 1'b0;
    end else if (act_ps_r == 4'h0) begin
      clk_out_r <= ~clk_out_r;
    end else begin
      clk_out_r <= (div_cnt_r < 8'(div_limit(act_ps_r) >> 1));
    end
  end

  // ----------------------------------------
  // Start-up delay
  // ----------------------------------------
  clk_presc_pkg::start_state_type st_r;
  logic [23:0] su_cnt_r;
  logic [23:0] su_target;
  always_comb begin
    su_target = 24'(`RESET_BASE_CYCLES);
    unique case (start_sel)
      2'b01: su_target = 24'(`RESET_BASE_CYCLES + START_FAST_CYCLES);
      2'b10: su_target = 24'(`RESET_BASE_CYCLES + START_SLOW_CYCLES);
      default: su_target = 24'(`RESET_BASE_CYCLES);
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= clk_presc_pkg::st_hold;
      su_cnt_r <= 24'h0;
    end else begin
      unique case (st_r)
        clk_presc_pkg::st_hold: begin
          if (ps_loaded_r) begin
            st_r <= clk_presc_pkg::st_delay;
            su_cnt_r <= 24'h0;
          end
        end
        clk_presc_pkg::st_delay: begin
          su_cnt_r <= su_cnt_r + 24'h1;
          if (su_cnt_r + 24'h1 >= su_target) begin
            st_r <= clk_presc_pkg::st_run;
          end
        end
        clk_presc_pkg::st_run: begin
          if (wake_s) begin
            st_r <= clk_presc_pkg::st_delay;
            su_cnt_r <= 24'(su_target - 24'(`WAKE_CYCLES));
          end
        end
        default: st_r <= clk_presc_pkg::st_hold;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sys_clk_en <= 1'b0;
      system_clock_output_pin <= 1'b0;
      ext_clock_select <= 1'b0;
      timer_osc_enable <= 1'b0;
      timer_ext_clock_accept <= 1'b0;
      startup_done <= 1'b0;
    end else begin
      sys_clk_en <= div_wrap && (st_r == clk_presc_pkg::st_run);
      // Output runs regardless of start-up state
      system_clock_output_pin <= clk_out_r;
      ext_clock_select <= (src_sel == `SRC_SEL_EXT_CLOCK);
      timer_osc_enable <= (src_sel == 4'h2) || (src_sel == 4'h3);
      timer_ext_clock_accept <= tmr_ext_r && ((src_sel == 4'h2) || (src_sel == 4'h3));
      startup_done <= (st_r == clk_presc_pkg::st_run);
    end
  end

  // Pin enable ignores reset so the pin is claimed while reset is held
  always_ff @(posedge core_clk) begin
    system_clock_output_oe_n <= !clk_out_fuse;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `PRESC_CTRL_OFFSET: prdata <= {24'h0, pce_r, 3'h0, ps_r};
          `CFG_OFFSET: prdata <= {31'h0, tmr_ext_r};
          `STATUS_OFFSET: prdata <= {27'h0, startup_done, act_ps_r};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_pce_timeout;
    @(posedge core_clk) disable iff (!rstn)
    $rose(pce_r) |-> ##4 !pce_r;
  endproperty
  a_pce_timeout: assert property (p_pce_timeout) else $error("enable not cleared");

  property p_pce_update;
    @(posedge core_clk) disable iff (!rstn)
    $rose(pce_r) |-> $past(pce_write);
  endproperty
  a_pce_update: assert property (p_pce_update) else $error("enable set badly");

  property p_ps_legal;
    @(posedge core_clk) disable iff (!rstn)
    ps_loaded_r |-> ps_r <= `PS_MAX_CODE;
  endproperty
  a_ps_legal: assert property (p_ps_legal) else $error("reserved code held");

  property p_ps_locked;
    @(posedge core_clk) disable iff (!rstn)
    ps_loaded_r && $past(ps_loaded_r) && $changed(ps_r) |-> $past(pce_r);
  endproperty
  a_ps_locked: assert property (p_ps_locked) else $error("select changed unlocked");

  property p_act_at_wrap;
    @(posedge core_clk) disable iff (!rstn)
    $changed(act_ps_r) |-> $past(div_wrap);
  endproperty
  a_act_at_wrap: assert property (p_act_at_wrap) else $error("mid-period switch");

  property p_div1;
    @(posedge core_clk) disable iff (!rstn)
    act_ps_r == 4'h0 |-> div_wrap;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one broken");

  property p_div2;
    @(posedge core_clk) disable iff (!rstn)
    act_ps_r == 4'h1 && div_wrap && ps_r == 4'h1 |-> ##1 !div_wrap ##1 div_wrap;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two broken");

  property p_oe;
    @(posedge core_clk) disable iff (!rstn)
    ##1 system_clock_output_oe_n == !$past(clk_out_fuse);
  endproperty
  a_oe: assert property (p_oe) else $error("clock output enable wrong");

  property p_ps_reset_load;
    @(posedge core_clk) disable iff (!rstn)
    $rose(ps_loaded_r) |-> ps_r == ($past(div8_fuse) ? `PS_RESET_DIV8 : `PS_RESET_DIV1);
  endproperty
  a_ps_reset_load: assert property (p_ps_reset_load) else $error("select reset wrong");

  property p_en_in_run;
    @(posedge core_clk) disable iff (!rstn)
    sys_clk_en |-> $past(st_r) == clk_presc_pkg::st_run;
  endproperty
  a_en_in_run: assert property (p_en_in_run) else $error("enable before startup");
endmodule : system_clock_prescaler_control

/* File: design/clk_presc_defs.svh */
`ifndef CLK_PRESC_DEFS_SVH
`define CLK_PRESC_DEFS_SVH
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define PRESC_CTRL_OFFSET 12'h000
`define CFG_OFFSET 12'h004
`define STATUS_OFFSET 12'h008
`define PCE_BIT 7
`define PS_MSB 3
`define PS_RESET_DIV1 4'h0
`define PS_RESET_DIV8 4'h3
`define PS_MAX_CODE 4'h8
`define SRC_SEL_EXT_CLOCK 4'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define PCE_TIMEOUT_CYCLES 3'h4
`define CLK_PERIOD_NS 8
`define START_FAST_US 4100
`define START_SLOW_US 65000
`define START_FAST_CYCLES ((`START_FAST_US * 1000) / `CLK_PERIOD_NS)
`define START_SLOW_CYCLES ((`START_SLOW_US * 1000) / `CLK_PERIOD_NS)
`define RESET_BASE_CYCLES 14
`define WAKE_CYCLES 6
`endif

/* File: design/clk_presc_pkg.sv */
package clk_presc_pkg;
  typedef enum logic [1:0] {
    st_hold = 2'b00,
    st_delay = 2'b01,
    st_run = 2'b11
  } start_state_type;
endpackage : clk_presc_pkg

/* File: tb/periph_model.sv */
`timescale 1ns/1ps
module periph_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Divided clock enable
  input wire logic sys_clk_en,
  // Spacing of the last two enables, and their count
  output logic [9:0] gap_r,
  output logic [15:0] edges_r
);
  logic [9:0] cnt_r;
  // -------------------------------
  // Peripheral stepping on the enable
  // -------------------------------
  // Peripherals only move on the shared enable, never on the raw clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 10'h001;
      gap_r <= 10'h000;
      edges_r <= 16'h0000;
    end else if (sys_clk_en) begin
      gap_r <= cnt_r;
      cnt_r <= 10'h001;
      edges_r <= edges_r + 16'h0001;
    end else begin
      cnt_r <= cnt_r + 10'h001;
    end
  end
endmodule : periph_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "clk_presc_defs.svh"
module tb;
  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] src_sel;
  logic [1:0] start_sel;
  logic div8, clk_out_fuse, wake, en, pin, oe_n, extsel, tosc, tacc, sdone, err;
  logic [9:0] gap_r;
  logic [15:0] edges_r;
  int fail_count = 0;
  int cmp_count = 0;
  system_clock_prescaler_control #(.START_FAST_CYCLES(20), .START_SLOW_CYCLES(20)) DUT (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_source_select_fuses(src_sel), .startup_time_fuses(start_sel),
    .initial_divide_by_eight_fuse(div8), .clock_output_fuse(clk_out_fuse),
    .wake_from_sleep(wake), .sys_clk_en(en), .system_clock_output_pin(pin),
    .system_clock_output_oe_n(oe_n), .ext_clock_select(extsel),
    .timer_osc_enable(tosc), .timer_ext_clock_accept(tacc), .startup_done(sdone));
  periph_model partner (.core_clk(core_clk), .rstn(rstn), .sys_clk_en(en),
    .gap_r(gap_r), .edges_r(edges_r));
  // -------------------------------
  // Clock, steady period
  // -------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task give_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge core_clk);
  endtask : apb
  task pin_period(input logic [31:0] exp);
    int n;
    int p;
    logic prev;
    n = 0;
    p = 0;
    do begin
      prev = pin;
      @(posedge core_clk);
      n++;
    end while (!(pin === 1'b1 && prev === 1'b0) && n < 2000);
    do begin
      prev = pin;
      @(posedge core_clk);
      p++;
    end while (!(pin === 1'b1 && prev === 1'b0) && p < 2000);
    if (n >= 2000) fail_count++;
    chk("pin period", exp, 32'(p));
  endtask : pin_period
  // Unlock and select back to back, nothing may slip between
  task set_div(input logic [31:0] code);
    apb(1'b1, `PRESC_CTRL_OFFSET, 32'h0000_0080);
    apb(1'b1, `PRESC_CTRL_OFFSET, code);
  endtask : set_div
  task measure(input logic [31:0] exp);
    logic [15:0] e0;
    int n;
    e0 = edges_r;
    n = 0;
    while (edges_r < e0 + 16'h0003 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000) fail_count++;
    chk("divided period", exp, {22'h0, gap_r});
  endtask : measure
  task do_reset;
    rstn <= 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask : do_reset
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end
  // -------------------------------
  // Main sequence
  // -------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {src_sel, start_sel, div8, clk_out_fuse, wake} = '0;
    rstn = 1'b0;
    do_reset();
    apb(1'b0, `PRESC_CTRL_OFFSET, 32'h0);
    chk("ctrl after reset", 32'h0000_0000, rd);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk("startup flag early", 32'h0, {31'h0, rd[4]});
    for (int c = 0; c <= 8; c++) begin
      set_div(32'(c));
      apb(1'b0, `PRESC_CTRL_OFFSET, 32'h0);
      chk("ctrl select", 32'(c), rd);
      measure(32'h1 << c);
    end
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk("startup flag", 32'h1, {31'h0, rd[4]});
    set_div(32'h2);
    apb(1'b1, `PRESC_CTRL_OFFSET, 32'h5);
    apb(1'b1, `PRESC_CTRL_OFFSET, 32'h80);
    repeat (5) @(posedge core_clk);
    apb(1'b1, `PRESC_CTRL_OFFSET, 32'h5);
    apb(1'b1, `PRESC_CTRL_OFFSET, 32'h81);
    apb(1'b1, `PRESC_CTRL_OFFSET, 32'h5);
    set_div(32'h9);
    apb(1'b0, `PRESC_CTRL_OFFSET, 32'h0);
    chk("ctrl kept", 32'h2, rd);
    measure(32'h4);
    set_div(32'h71);
    apb(1'b0, `PRESC_CTRL_OFFSET, 32'h0);
    chk("ctrl unused bits", 32'h1, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    clk_out_fuse <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("clock out drive", 32'h0, {31'h0, oe_n});
    chk("ext clock", 32'h1, {31'h0, extsel});
    chk("timer osc off", 32'h0, {31'h0, tosc});
    src_sel <= 4'h2;
    apb(1'b1, `CFG_OFFSET, 32'h1);
    repeat (4) @(posedge core_clk);
    chk("timer osc on", 32'h1, {31'h0, tosc});
    chk("timer ext accept", 32'h1, {31'h0, tacc});
    div8 <= 1'b1;
    do_reset();
    apb(1'b0, `PRESC_CTRL_OFFSET, 32'h0);
    chk("ctrl div8 reset", 32'h3, rd);
    measure(32'h8);
    pin_period(32'h8);
    chk("startup done", 32'h1, {31'h0, sdone});
    give_verdict();
  end
endmodule : tb
